// File: common/usp_pkg.sv
// package for the schedule pointer register bank: offsets, fields, timing
package usp_pkg;

  // ****************************************************
  // register offsets (byte addresses in operational space)
  // ****************************************************
  localparam logic [7:0] USP_OFS_FRAME_INDEX = 8'h2C;
  localparam logic [7:0] USP_OFS_PERIODIC_START = 8'h34;
  localparam logic [7:0] USP_OFS_ASYNC_POINTER = 8'h38;

  // ****************************************************
  // field layout and reset values
  // ****************************************************
  localparam int USP_FIDX_W = 14;
  localparam int USP_SOF_HI = 13;
  localparam int USP_SOF_LO = 3;
  localparam int USP_PBASE_LO = 12;
  localparam int USP_ASYNC_LO = 5;
  localparam logic [13:0] USP_FIDX_RST = 14'h0000;
  localparam logic [31:0] USP_PBASE_RST = 32'h0000_0000;
  localparam logic [31:0] USP_ASYNC_RST = 32'h0000_0000;
  localparam logic [31:0] USP_PBASE_MASK = 32'hFFFF_F000;
  localparam logic [31:0] USP_ASYNC_MASK = 32'hFFFF_FFE0;
  localparam logic [31:0] USP_FIDX_MASK = 32'h0000_3FFF;
  localparam logic [31:0] USP_SEG_RST = 32'h0000_0000;

  // list size selection encodings
  localparam logic [1:0] USP_FLS_1024 = 2'h0;
  localparam logic [1:0] USP_FLS_512 = 2'h1;
  localparam logic [1:0] USP_FLS_256 = 2'h2;

  // ****************************************************
  // timing: one microframe
  // ****************************************************
  localparam int USP_CLK_PERIOD_PS = 4000;
  localparam int USP_UFRAME_NS = 125000;
  localparam int USP_UFRAME_CYC = (USP_UFRAME_NS * 1000) / USP_CLK_PERIOD_PS;

  // register access request from the operational space decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } usp_req_s;

  // fetch address bundle for the schedule fetch engine
  typedef struct packed {
    logic [63:0] periodic_addr;
    logic [63:0] async_addr;
    logic [10:0] sof_frame;
  } usp_fetch_s;

endpackage

// File: rtl/usp_sched_ptrs.sv
// schedule pointer register bank: frame index, periodic list start, async queue pointer
`timescale 1ns/10ps
// ****************************************************
// ****************************************************
module usp_sched_ptrs
  import usp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire usp_req_s i_req,
  input wire logic [1:0] i_frame_list_size_sel,
  input wire logic i_run_stop,
  input wire logic i_halted_flag,
  input wire logic i_wide_addr_capable,
  input wire logic [31:0] i_upper_address_segment,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output usp_fetch_s o_fetch,
  output logic o_frame_tick
);

  // ****************************************************
  // helpers
  // ****************************************************
  // index slice of the counter placed on the list entry word offset
  function automatic logic [11:0] list_offset(input logic [1:0] sel,
                                              input logic [13:0] fidx);
    logic [11:0] ofs;
    ofs = 12'h000;
    case (sel)
      USP_FLS_512: ofs = {2'h0, fidx[11:3], 1'b0} << 1;
      USP_FLS_256: ofs = {3'h0, fidx[10:3], 1'b0} << 1;
      default: ofs = {fidx[12:3], 2'h0};
    endcase
    return ofs;
  endfunction

  // widen a 32-bit structure pointer with the segment when capable
  function automatic logic [63:0] widen(input logic cap, input logic [31:0] seg,
                                        input logic [31:0] lo);
    return {(cap ? seg : USP_SEG_RST), lo};
  endfunction

  // ****************************************************
  // state
  // ****************************************************
  logic [13:0] frame_index;
  logic [31:0] periodic_start;
  logic [31:0] async_ptr;
  logic [16:0] uframe_cnt;
  logic end_of_uframe;
  logic fidx_wr;
  logic [31:0] next_rdata;

  assign end_of_uframe = (uframe_cnt == 17'(USP_UFRAME_CYC - 1));
  // writes only land while halted and not running; others would be undefined anyway
  assign fidx_wr = i_req.wr && (i_req.addr == USP_OFS_FRAME_INDEX)
                   && i_halted_flag && !i_run_stop;

  // microframe timer runs only while the schedule runs
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      uframe_cnt <= 17'h00000;
    end else if (!i_run_stop || end_of_uframe || fidx_wr) begin
      uframe_cnt <= 17'h00000;
    end else begin
      uframe_cnt <= uframe_cnt + 17'h00001;
    end
  end

  // frame index: write while halted, otherwise count each microframe end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      frame_index <= USP_FIDX_RST;
    end else if (fidx_wr) begin
      frame_index <= i_req.wdata[13:0];
    end else if (i_run_stop && end_of_uframe) begin
      frame_index <= frame_index + 14'h0001;
    end
  end

  // periodic list start, reserved low bits held at zero
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      periodic_start <= USP_PBASE_RST;
    end else if (i_req.wr && (i_req.addr == USP_OFS_PERIODIC_START)) begin
      periodic_start <= i_req.wdata & USP_PBASE_MASK;
    end
  end

  // async queue pointer; low five bits never stored so they read zero
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      async_ptr <= USP_ASYNC_RST;
    end else if (i_req.wr && (i_req.addr == USP_OFS_ASYNC_POINTER)) begin
      async_ptr <= i_req.wdata & USP_ASYNC_MASK;
    end
  end

  // ****************************************************
  // read path
  // ****************************************************
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_req.addr == USP_OFS_FRAME_INDEX) begin
      next_rdata = {18'h00000, frame_index};
    end else if (i_req.addr == USP_OFS_PERIODIC_START) begin
      next_rdata = periodic_start;
    end else if (i_req.addr == USP_OFS_ASYNC_POINTER) begin
      next_rdata = async_ptr & USP_ASYNC_MASK;
    end
  end

  // registered read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
      o_rdata <= i_req.rd ? next_rdata : 32'h0000_0000;
    end
  end

  // ****************************************************
  // fetch addresses for the schedule engine
  // ****************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fetch <= '0;
      o_frame_tick <= 1'b0;
    end else begin
      o_fetch.periodic_addr <= widen(i_wide_addr_capable, i_upper_address_segment,
        {periodic_start[31:12], list_offset(i_frame_list_size_sel, frame_index)});
      o_fetch.async_addr <= widen(i_wide_addr_capable, i_upper_address_segment,
        async_ptr);
      o_fetch.sof_frame <= frame_index[USP_SOF_HI:USP_SOF_LO];
      o_frame_tick <= i_run_stop && end_of_uframe;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  logic [13:0] past_fidx_chk;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      past_fidx_chk <= USP_FIDX_RST;
    end else begin
      past_fidx_chk <= frame_index;
    end
  end

  // a counted microframe end, then one step of the index with the tick beside it
  sequence s_uframe_end;
    i_run_stop && end_of_uframe && !fidx_wr;
  endsequence

  sequence s_tick_then_step;
    o_frame_tick && (frame_index == 14'(past_fidx_chk + 14'h0001));
  endsequence

  a_index_steps: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_uframe_end |=> s_tick_then_step)
    else $error("frame index did not advance at microframe end");
  a_tick_period: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (uframe_cnt == 17'h00000 && i_run_stop) |-> !end_of_uframe)
    else $error("microframe ended too early");
  a_sof_bits: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ##1 (o_fetch.sof_frame == past_fidx_chk[13:3]))
    else $error("sof frame number wrong bits");
  a_list_1024: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_frame_list_size_sel == USP_FLS_1024)
      |=> (o_fetch.periodic_addr[11:2] == past_fidx_chk[12:3]))
    else $error("1024 entry index wrong");
  a_base_align: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    periodic_start[11:0] == 12'h000)
    else $error("periodic start low bits not reserved");
  a_async_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_rvalid |-> (!$past(i_req.addr == USP_OFS_ASYNC_POINTER) || o_rdata[4:0] == 5'h00))
    else $error("async pointer low bits read nonzero");
  a_async_store: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_req.wr && i_req.addr == USP_OFS_ASYNC_POINTER)
      |=> (async_ptr == ($past(i_req.wdata) & USP_ASYNC_MASK)))
    else $error("async pointer not stored");
  a_wide_seg: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wide_addr_capable |=> (o_fetch.async_addr[63:32] == $past(i_upper_address_segment)))
    else $error("segment not used for upper address");
  a_eight_visits: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_frame_tick && frame_index[2:0] != 3'h0) |=> $stable(o_fetch.sof_frame))
    else $error("entry advanced early");

  // ****************************************************
  // tick spacing checker
  // ****************************************************
  // a microframe is far longer than any repetition the tools can unroll,
  // so a small counter carries the span between two ticks instead
  logic [16:0] tick_gap_chk;
  logic tick_seen_chk;

  // cycles since the last tick; cleared while stopped so a restart is not judged
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_gap_chk <= 17'h00000;
      tick_seen_chk <= 1'b0;
    end else if (!i_run_stop) begin
      tick_gap_chk <= 17'h00000;
      tick_seen_chk <= 1'b0;
    end else if (o_frame_tick) begin
      tick_gap_chk <= 17'h00001;
      tick_seen_chk <= 1'b1;
    end else if (tick_gap_chk != 17'h1FFFF) begin
      tick_gap_chk <= tick_gap_chk + 17'h00001; // saturates, never wraps to a false match
    end
  end

  // two ticks in one run are exactly one microframe apart
  a_tick_spacing: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_frame_tick && tick_seen_chk) |-> (tick_gap_chk == 17'(USP_UFRAME_CYC)))
    else $error("frame tick spacing wrong");

  // ****************************************************
  // register write checks
  // ****************************************************
  // a frame index write while running, away from a microframe end, must leave the index alone
  a_refused_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_req.wr && i_req.addr == USP_OFS_FRAME_INDEX && i_run_stop && !end_of_uframe)
      |=> $stable(frame_index))
    else $error("frame index written while running");

  // a halted write lands in full, reserved upper bits dropped
  a_halted_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_req.wr && i_req.addr == USP_OFS_FRAME_INDEX && i_halted_flag && !i_run_stop)
      |=> (frame_index == $past(i_req.wdata[13:0])))
    else $error("halted frame index write lost");

  // the list start keeps only address bits 31 to 12
  a_base_store: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_req.wr && i_req.addr == USP_OFS_PERIODIC_START)
      |=> (periodic_start == ($past(i_req.wdata) & USP_PBASE_MASK)))
    else $error("periodic start not stored");

  // ****************************************************
  // read answer checks
  // ****************************************************
  // every read strobe gets exactly one answer one cycle later
  a_read_answer: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_req.rd |=> o_rvalid)
    else $error("read answer missing");

  // no answer without a strobe, and idle read data stays at zero
  a_read_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_req.rd |=> (!o_rvalid && o_rdata == 32'h0000_0000))
    else $error("spurious read answer");

  // a pointer read returns the stored queue head address
  a_async_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == USP_OFS_ASYNC_POINTER)
      |=> (o_rdata == $past(async_ptr)))
    else $error("async pointer read wrong");

  // ****************************************************
  // fetch address checks
  // ****************************************************
  // smaller lists keep the index in the low entry bits, the rest stays zero
  a_list_512: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_frame_list_size_sel == USP_FLS_512)
      |=> (o_fetch.periodic_addr[11:2] == {1'b0, past_fidx_chk[11:3]}))
    else $error("512 entry index wrong");

  a_list_256: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_frame_list_size_sel == USP_FLS_256)
      |=> (o_fetch.periodic_addr[11:2] == {2'h0, past_fidx_chk[10:3]}))
    else $error("256 entry index wrong");

  // the upper fetch bits always carry the stored base
  a_fetch_base: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    1'b1 |=> (o_fetch.periodic_addr[31:12] == $past(periodic_start[31:12])))
    else $error("periodic fetch base wrong");

  // without wide addressing the upper halves must read zero
  a_narrow_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_wide_addr_capable
      |=> (o_fetch.async_addr[63:32] == 32'h0000_0000
           && o_fetch.periodic_addr[63:32] == 32'h0000_0000))
    else $error("upper address not zero when narrow");

endmodule // usp_sched_ptrs

// File: verification/usp_host_model.sv
// host software model: issues register accesses to the pointer bank
`timescale 1ns/10ps
module usp_host_model
  import usp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid,
  output usp_req_s o_req
);
  initial o_req = '0;
  // ****
  // access tasks
  // ****
  // callers may pass bases with reserved low bits set, as the async pointer write does; base loaded before run
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_ref_clk);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_ref_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d}; // released data no longer valid
  endtask
  // answer is fixed one cycle after the taking edge, so no open wait here
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(negedge i_ref_clk);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge i_ref_clk);
    d = i_rdata;
    v = i_rvalid;
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hFFFF_FFFF};
  endtask
endmodule // usp_host_model

// File: verification/usp_sched_ptrs_tb.sv
// testbench for the schedule pointer register bank
`timescale 1ns/10ps
module usp_sched_ptrs_tb;
  import usp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] frame_list_size_sel = USP_FLS_1024;
  logic run = 1'b0;
  logic hlt = 1'b1;
  logic wide = 1'b0;
  logic [31:0] seg = 32'h0000_00A5;
  usp_req_s req;
  logic [31:0] rdata;
  logic rvalid;
  logic tick;
  usp_fetch_s fetch;
  int n_errors = 0;
  int num_checks = 0;
  int n;
  always #2 clk = ~clk;
  usp_sched_ptrs DUT(.i_ref_clk(clk), .i_rst(rst), .i_req(req), .i_frame_list_size_sel(frame_list_size_sel),
    .i_run_stop(run), .i_halted_flag(hlt), .i_wide_addr_capable(wide),
    .i_upper_address_segment(seg), .o_rdata(rdata), .o_rvalid(rvalid), .o_fetch(fetch),
    .o_frame_tick(tick));
  usp_host_model host(.i_ref_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
  // ****
  // checking helpers
  // ****
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // valid flag and data checked together
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    host.rd_reg(a, d, v);
    chk({31'h0, v, d}, {32'h1, exp});
  endtask
  // list index is frame index bits N..3, four bytes an entry
  function automatic logic [63:0] exp_per(logic [13:0] fi, logic [1:0] s, logic w);
    logic [13:0] m;
    m = (s == 2'h0) ? 14'h3FF : (s == 2'h1) ? 14'h1FF : 14'hFF;
    return {w ? seg : 32'h0, 32'hABCDE000 | {16'h0, ((fi >> 3) & m), 2'h0}};
  endfunction
  // bounded: the 40000-cycle limit lies only about a quarter above one microframe of 31250 cycles
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (tick !== 1'b1 && c < 40000);
    if (tick !== 1'b1) begin
      n_errors++;
      finish_test();
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd_chk(USP_OFS_FRAME_INDEX, 32'h0);
    rd_chk(USP_OFS_PERIODIC_START, 32'h0);
    rd_chk(USP_OFS_ASYNC_POINTER, 32'h0);
    rd_chk(8'h30, 32'h0);
    host.wr_reg(USP_OFS_PERIODIC_START, 32'hABCDE000);
    // low bits set on purpose to see them masked
    host.wr_reg(USP_OFS_ASYNC_POINTER, 32'h1234567F);
    host.wr_reg(USP_OFS_FRAME_INDEX, 32'h00001ABC);
    rd_chk(USP_OFS_PERIODIC_START, 32'hABCDE000);
    rd_chk(USP_OFS_ASYNC_POINTER, 32'h12345660);
    rd_chk(USP_OFS_FRAME_INDEX, 32'h00001ABC);
    for (int i = 0; i < 3; i++) begin
      frame_list_size_sel = i[1:0];
      wide = i[0];
      repeat (3) @(negedge clk);
      chk(fetch.periodic_addr, exp_per(14'h1ABC, frame_list_size_sel, wide));
      chk(fetch.async_addr, {wide ? seg : 32'h0, 32'h12345660});
    end
    chk({53'h0, fetch.sof_frame}, 64'h357);
    host.wr_reg(USP_OFS_FRAME_INDEX, 32'h00003FFF);
    run = 1'b1;
    hlt = 1'b0;
    host.wr_reg(USP_OFS_FRAME_INDEX, 32'h00000005);
    rd_chk(USP_OFS_FRAME_INDEX, 32'h00003FFF);
    wait_tick(n);
    wait_tick(n);
    chk(64'(n), 64'(USP_UFRAME_CYC));
    rd_chk(USP_OFS_FRAME_INDEX, 32'h00000001);
    chk({53'h0, fetch.sof_frame}, 64'h0);
    chk(fetch.periodic_addr, exp_per(14'h1, frame_list_size_sel, wide));
    finish_test();
  end
endmodule // usp_sched_ptrs_tb
